// File: hdl/vcs_device.sv
// codec end of the serial pcm port: transmit shifter, receive shifter, mode detect
//
// Behaviour
// - words travel msb first, lsb last
// - 8 bits companded, 16 bits linear
// - fixed: bits driven after master rising edges
// - fixed: release data after last falling edge
// - fixed: strobe low after bit 1 rising
// - fixed: strobe high after last falling edge
// - fixed: frame start seen on falling edge
// - fixed: receive sampled on master falling edges
// - variable: bit 1 follows frame sync rising
// - variable: later bits on bit clock rising
// - variable: release data when frame sync low
// - variable: receive sampled on bit clock falling
// - variable: frame start on bit clock falling
// - variable: host drops tx sync after last bit
// - receive bit clock high selects fixed mode
// - variable: word repeats while sync stays high
// - host bit clocks synchronous to master
// - fixed: master clock shifts both directions
`timescale 1ns/100ps
module vcs_device
  import vcs_pkg::*;
#(
  parameter int unsigned MODE_HOLD = VCS_MODE_HOLD
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  vcs_if.dev link,
  input wire logic linear_mode_i,
  input wire logic [VCS_WORD_W-1:0] tx_word_i,
  output logic tx_load_o,
  output logic [VCS_WORD_W-1:0] rx_word_o,
  output logic rx_valid_o,
  output logic var_mode_o
);

  initial
  begin
    if (MODE_HOLD < 2 * VCS_MCLK_HALF || MODE_HOLD > 65535)
      $error("vcs_device: MODE_HOLD out of range");
  end

  // link pins: {mclk, tx sync, rx sync, tx bit clock, rx bit clock, din}
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [5:0] prev_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // bit clocks idle high: resetting to their idle level avoids a false edge and a false mode
      meta_q <= 6'h06;
      sync_q <= 6'h06;
      prev_q <= 6'h06;
    end
    else
    begin
      meta_q <= {link.mclk, link.tx_frame_sync, link.rx_frame_sync,
                 link.tx_bit_clock, link.rx_bit_clock, link.din};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire logic tx_sync_s = sync_q[4];
  wire logic rx_sync_s = sync_q[3];
  wire logic rx_bclk_s = sync_q[1];
  wire logic din_s = sync_q[0];
  wire logic m_rise = sync_q[5] & ~prev_q[5];
  wire logic m_fall = ~sync_q[5] & prev_q[5];
  wire logic tx_sync_rise = sync_q[4] & ~prev_q[4];
  wire logic x_rise = sync_q[2] & ~prev_q[2];
  wire logic x_fall = ~sync_q[2] & prev_q[2];
  wire logic r_fall = ~sync_q[1] & prev_q[1];

  // mode detect: a receive bit clock that stays high long enough means fixed rate
  logic var_q;
  logic [15:0] hold_cnt_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      var_q <= 1'b0;
      hold_cnt_q <= 16'h0000;
    end
    else if (!rx_bclk_s)
    begin
      var_q <= 1'b1;
      hold_cnt_q <= 16'h0000;
    end
    else if (hold_cnt_q == 16'(MODE_HOLD))
      var_q <= 1'b0;
    else
      hold_cnt_q <= hold_cnt_q + 16'h0001;
  end

  assign var_mode_o = var_q;

  // transmit side
  vcs_tx_state_t tx_state_q;
  logic [VCS_WORD_W-1:0] tx_sh_q;
  logic [VCS_WORD_W-1:0] tx_hold_q;
  logic [VCS_CNT_W-1:0] tx_cnt_q;
  logic [VCS_CNT_W-1:0] tx_len_q;
  logic tx_frame_ok_q;
  logic dout_q;
  logic dout_oe_n_q;
  logic stb_oe_n_q;
  logic tx_load_q;
  // companded words sit in the top byte so the msb is always bit 15
  wire logic [VCS_WORD_W-1:0] tx_word_al = linear_mode_i ? tx_word_i : {tx_word_i[7:0], 8'h00};
  wire logic [VCS_CNT_W-1:0] len_now = linear_mode_i ? VCS_CNT_W'(VCS_LEN_LIN) : VCS_CNT_W'(VCS_LEN_COMP);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_state_q <= VCS_TX_IDLE;
      tx_sh_q <= 16'h0000;
      tx_hold_q <= 16'h0000;
      tx_cnt_q <= '0;
      tx_len_q <= VCS_CNT_W'(VCS_LEN_COMP);
      tx_frame_ok_q <= 1'b0;
      dout_q <= VCS_LINE_IDLE;
      dout_oe_n_q <= VCS_OE_OFF_N;
      stb_oe_n_q <= VCS_OE_OFF_N;
      tx_load_q <= 1'b0;
    end
    else
    begin
      tx_load_q <= 1'b0;
      case (tx_state_q)
        VCS_TX_IDLE:
        begin
          if (!var_q && m_fall && tx_sync_s)
          begin
            tx_sh_q <= tx_word_al;
            tx_hold_q <= tx_word_al;
            tx_len_q <= len_now;
            tx_load_q <= 1'b1;
            tx_state_q <= VCS_TX_ARM;
          end
          else if (var_q && tx_sync_rise)
          begin
            tx_sh_q <= tx_word_al;
            tx_hold_q <= tx_word_al;
            tx_len_q <= len_now;
            tx_load_q <= 1'b1;
            dout_q <= tx_word_al[VCS_WORD_W-1];
            dout_oe_n_q <= VCS_OE_ON_N;
            stb_oe_n_q <= VCS_OE_ON_N;
            tx_cnt_q <= VCS_CNT_W'(1);
            tx_frame_ok_q <= 1'b0;
            tx_state_q <= VCS_TX_SHIFT;
          end
        end
        VCS_TX_ARM:
        begin
          if (m_rise)
          begin
            dout_q <= tx_sh_q[VCS_WORD_W-1];
            dout_oe_n_q <= VCS_OE_ON_N;
            stb_oe_n_q <= VCS_OE_ON_N;
            tx_cnt_q <= VCS_CNT_W'(1);
            tx_state_q <= VCS_TX_SHIFT;
          end
        end
        VCS_TX_SHIFT:
        begin
          if (!var_q)
          begin
            if (m_rise && tx_cnt_q != tx_len_q)
            begin
              tx_sh_q <= tx_sh_q << 1;
              dout_q <= tx_sh_q[VCS_WORD_W-2];
              tx_cnt_q <= tx_cnt_q + VCS_CNT_W'(1);
            end
            else if (m_fall && tx_cnt_q == tx_len_q)
            begin
              dout_oe_n_q <= VCS_OE_OFF_N;
              stb_oe_n_q <= VCS_OE_OFF_N;
              dout_q <= VCS_LINE_IDLE;
              tx_state_q <= VCS_TX_IDLE;
            end
          end
          else if (!tx_sync_s)
          begin
            dout_oe_n_q <= VCS_OE_OFF_N;
            stb_oe_n_q <= VCS_OE_OFF_N;
            dout_q <= VCS_LINE_IDLE;
            tx_state_q <= VCS_TX_IDLE;
          end
          else if (x_fall)
            tx_frame_ok_q <= 1'b1;
          else if (x_rise && tx_frame_ok_q)
          begin
            if (tx_cnt_q == tx_len_q)
            begin
              tx_sh_q <= tx_hold_q;
              dout_q <= tx_hold_q[VCS_WORD_W-1];
              tx_cnt_q <= VCS_CNT_W'(1);
            end
            else
            begin
              tx_sh_q <= tx_sh_q << 1;
              dout_q <= tx_sh_q[VCS_WORD_W-2];
              tx_cnt_q <= tx_cnt_q + VCS_CNT_W'(1);
            end
          end
        end
        default:
        begin
          tx_state_q <= VCS_TX_IDLE;
          dout_oe_n_q <= VCS_OE_OFF_N;
          stb_oe_n_q <= VCS_OE_OFF_N;
        end
      endcase
    end
  end

  assign link.dout = dout_q;
  assign link.dout_oe_n = dout_oe_n_q;
  // strobe only pulls low while enabled, so its data may follow the enable
  assign link.tx_slot_strobe_n_out = stb_oe_n_q;
  assign link.tx_slot_strobe_n_oe_n = stb_oe_n_q;
  assign tx_load_o = tx_load_q;

  // receive side
  logic rx_busy_q;
  logic [VCS_WORD_W-1:0] rx_sh_q;
  logic [VCS_CNT_W-1:0] rx_cnt_q;
  logic [VCS_CNT_W-1:0] rx_len_q;
  logic [VCS_WORD_W-1:0] rx_word_q;
  logic rx_valid_q;
  wire logic r_edge = var_q ? r_fall : m_fall;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_busy_q <= 1'b0;
      rx_sh_q <= 16'h0000;
      rx_cnt_q <= '0;
      rx_len_q <= VCS_CNT_W'(VCS_LEN_COMP);
      rx_word_q <= 16'h0000;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= 1'b0;
      if (!rx_busy_q && r_edge && rx_sync_s)
      begin
        rx_sh_q <= {15'h0000, din_s};
        rx_cnt_q <= VCS_CNT_W'(1);
        rx_len_q <= len_now;
        rx_busy_q <= 1'b1;
      end
      else if (rx_busy_q && r_edge)
      begin
        rx_sh_q <= {rx_sh_q[VCS_WORD_W-2:0], din_s};
        rx_cnt_q <= rx_cnt_q + VCS_CNT_W'(1);
        if (rx_cnt_q + VCS_CNT_W'(1) == rx_len_q)
        begin
          // hand over only once the last bit is in
          rx_word_q <= {rx_sh_q[VCS_WORD_W-2:0], din_s};
          rx_valid_q <= 1'b1;
          rx_busy_q <= 1'b0;
        end
      end
    end
  end

  assign rx_word_o = rx_word_q;
  assign rx_valid_o = rx_valid_q;

endmodule // vcs_device

// File: hdl/vcs_pkg.sv
// shared constants and state types of the voice codec serial port
package vcs_pkg;

  localparam int unsigned VCS_LEN_COMP = 8;
  localparam int unsigned VCS_LEN_LIN = 16;
  localparam int unsigned VCS_WORD_W = 16;
  localparam int unsigned VCS_CNT_W = 5;

  localparam int unsigned VCS_SYS_PERIOD_NS = 20;
  localparam int unsigned VCS_MCLK_PERIOD_NS = 320;
  localparam int unsigned VCS_MCLK_HALF = VCS_MCLK_PERIOD_NS / (2 * VCS_SYS_PERIOD_NS);
  localparam int unsigned VCS_MODE_HOLD_NS = 1280;
  localparam int unsigned VCS_MODE_HOLD = VCS_MODE_HOLD_NS / VCS_SYS_PERIOD_NS;

  localparam logic VCS_LINE_IDLE = 1'b1;
  localparam logic VCS_OE_OFF_N = 1'b1;
  localparam logic VCS_OE_ON_N = 1'b0;

  typedef enum logic [2:0] {
    VCS_TX_IDLE = 3'b001,
    VCS_TX_ARM = 3'b010,
    VCS_TX_SHIFT = 3'b100
  } vcs_tx_state_t;

  typedef enum logic [1:0] {
    VCS_H_IDLE = 2'b01,
    VCS_H_RUN = 2'b10
  } vcs_host_state_t;

endpackage

// File: hdl/vcs_if.sv
// serial link between codec port and its host
`timescale 1ns/100ps
interface vcs_if;
  logic mclk;
  logic tx_frame_sync;
  logic rx_frame_sync;
  logic tx_bit_clock;
  logic rx_bit_clock;
  logic din;
  logic dout;
  logic dout_oe_n;
  logic tx_slot_strobe_n_out;
  logic tx_slot_strobe_n_oe_n;
  logic dout_line;
  logic tx_slot_strobe_n;

  // released lines park high, as a pull-up would leave them
  assign dout_line = dout_oe_n ? 1'b1 : dout;
  assign tx_slot_strobe_n = tx_slot_strobe_n_oe_n ? 1'b1 : tx_slot_strobe_n_out;

  modport dev (
    input mclk, tx_frame_sync, rx_frame_sync, tx_bit_clock, rx_bit_clock, din,
    output dout, dout_oe_n, tx_slot_strobe_n_out, tx_slot_strobe_n_oe_n
  );
  modport host (
    output mclk, tx_frame_sync, rx_frame_sync, tx_bit_clock, rx_bit_clock, din,
    input dout_line, tx_slot_strobe_n
  );
endinterface

// File: hdl/vcs_host.sv
// host end of the serial pcm port: makes master and bit clocks, syncs and receive data
`timescale 1ns/100ps
module vcs_host
  import vcs_pkg::*;
#(
  parameter int unsigned MCLK_HALF = VCS_MCLK_HALF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  vcs_if.host link,
  input wire logic linear_mode_i,
  input wire logic var_mode_i,
  input wire logic start_i,
  input wire logic [VCS_WORD_W-1:0] word_i,
  output logic busy_o,
  output logic [VCS_WORD_W-1:0] rx_word_o,
  output logic rx_valid_o
);

  // the device needs ~4 cycles to answer and this end 2 more to sample
  initial
  begin
    if (MCLK_HALF < 8 || MCLK_HALF > 255)
      $error("vcs_host: MCLK_HALF out of range");
  end

  logic [7:0] div_q;
  logic mclk_q;
  logic bclk_q;
  logic rise_ev;
  logic fall_ev;

  assign rise_ev = (div_q == 8'(MCLK_HALF - 1)) && !mclk_q;
  assign fall_ev = (div_q == 8'(MCLK_HALF - 1)) && mclk_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q <= 8'h00;
      mclk_q <= 1'b0;
      bclk_q <= 1'b1;
    end
    else
    begin
      div_q <= (div_q == 8'(MCLK_HALF - 1)) ? 8'h00 : div_q + 8'h01;
      if (div_q == 8'(MCLK_HALF - 1))
        mclk_q <= ~mclk_q;
      // bit clocks are held high in fixed mode and copy the master in variable mode, so synchronous by construction
      if (!var_mode_i)
        bclk_q <= 1'b1;
      else if (div_q == 8'(MCLK_HALF - 1))
        bclk_q <= ~mclk_q;
    end
  end

  logic dout_meta_q;
  logic dout_s_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dout_meta_q <= 1'b1;
      dout_s_q <= 1'b1;
    end
    else
    begin
      dout_meta_q <= link.dout_line;
      dout_s_q <= dout_meta_q;
    end
  end

  vcs_host_state_t state_q;
  logic pend_q;
  logic vm_q;
  logic tx_sync_q;
  logic rx_sync_q;
  logic din_q;
  logic [VCS_WORD_W-1:0] tx_sh_q;
  logic [VCS_WORD_W-1:0] rx_sh_q;
  logic [VCS_CNT_W-1:0] len_q;
  logic [VCS_CNT_W-1:0] fcnt_q;
  logic [VCS_WORD_W-1:0] rx_word_q;
  logic rx_valid_q;
  logic [VCS_CNT_W-1:0] k;
  logic [VCS_WORD_W-1:0] rx_next;

  assign k = fcnt_q + VCS_CNT_W'(1);
  assign rx_next = {rx_sh_q[VCS_WORD_W-2:0], dout_s_q};

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= VCS_H_IDLE;
      pend_q <= 1'b0;
      vm_q <= 1'b0;
      tx_sync_q <= 1'b0;
      rx_sync_q <= 1'b0;
      din_q <= 1'b0;
      tx_sh_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
      len_q <= VCS_CNT_W'(VCS_LEN_COMP);
      fcnt_q <= '0;
      rx_word_q <= 16'h0000;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= 1'b0;
      case (state_q)
        VCS_H_IDLE:
        begin
          if (start_i && !pend_q)
          begin
            pend_q <= 1'b1;
            tx_sh_q <= linear_mode_i ? word_i : {word_i[7:0], 8'h00};
            len_q <= linear_mode_i ? VCS_CNT_W'(VCS_LEN_LIN) : VCS_CNT_W'(VCS_LEN_COMP);
            vm_q <= var_mode_i;
          end
          else if (pend_q && rise_ev)
          begin
            tx_sync_q <= 1'b1;
            rx_sync_q <= 1'b1;
            din_q <= tx_sh_q[VCS_WORD_W-1];
            tx_sh_q <= tx_sh_q << 1;
            // cleared so a short companded word leaves the top byte zero
            rx_sh_q <= 16'h0000;
            fcnt_q <= '0;
            state_q <= VCS_H_RUN;
          end
        end
        VCS_H_RUN:
        begin
          if (rise_ev)
          begin
            din_q <= tx_sh_q[VCS_WORD_W-1];
            tx_sh_q <= tx_sh_q << 1;
            // syncs stay high across the falling edge that takes them
            if (fcnt_q == VCS_CNT_W'(1))
            begin
              rx_sync_q <= 1'b0;
              if (!vm_q)
                tx_sync_q <= 1'b0;
            end
          end
          else if (fall_ev)
          begin
            fcnt_q <= k;
            if (vm_q || k != VCS_CNT_W'(1))
              rx_sh_q <= rx_next;
            if ((vm_q && k == len_q) || (!vm_q && k == len_q + VCS_CNT_W'(1)))
            begin
              tx_sync_q <= 1'b0;
              rx_word_q <= rx_next;
              rx_valid_q <= 1'b1;
              pend_q <= 1'b0;
              state_q <= VCS_H_IDLE;
            end
          end
        end
        default:
          state_q <= VCS_H_IDLE;
      endcase
    end
  end

  assign link.mclk = mclk_q;
  assign link.tx_bit_clock = bclk_q;
  assign link.rx_bit_clock = bclk_q;
  assign link.tx_frame_sync = tx_sync_q;
  assign link.rx_frame_sync = rx_sync_q;
  assign link.din = din_q;
  assign busy_o = pend_q;
  assign rx_word_o = rx_word_q;
  assign rx_valid_o = rx_valid_q;

endmodule // vcs_host

// File: tb/vcs_assertions.sv
// concurrent checks on the serial link between codec port and host
`timescale 1ns/100ps
module vcs_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic mclk,
  input wire logic tx_frame_sync,
  input wire logic rx_frame_sync,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic tx_slot_strobe_n_oe_n
);
  logic mclk_q;
  logic [4:0] bits_q;
  logic [5:0] age_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mclk_q <= 1'b0;
    else
      mclk_q <= mclk;
  end

  // falling master edges seen while the data line is driven
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bits_q <= 5'h00;
    else if (dout_oe_n)
      bits_q <= 5'h00;
    else if (mclk_q && !mclk)
      bits_q <= bits_q + 5'h01;
  end

  // age since last frame sync; starts saturated so no drive is excused after reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      age_q <= 6'h3f;
    else if (tx_frame_sync)
      age_q <= 6'h00;
    else if (age_q != 6'h3f)
      age_q <= age_q + 6'h01;
  end

  a_strobe_with_data: assert property (tx_slot_strobe_n_oe_n == dout_oe_n)
    else $error("strobe and data enable differ");
  a_drive_on_rise: assert property ($fell(dout_oe_n) |-> mclk && age_q < 6'h10)
    else $error("data driven off a frame start");
  a_bit_on_rise: assert property (!dout_oe_n && !$past(dout_oe_n) && $changed(dout) |-> mclk)
    else $error("data bit changed while clock low");
  a_release_after_fall: assert property ($rose(dout_oe_n) |-> !mclk)
    else $error("data released off a falling edge");
  a_word_length: assert property ($rose(dout_oe_n) |-> bits_q == 5'h08 || bits_q == 5'h10)
    else $error("word length not 8 or 16");
  a_sync_held: assert property ($rose(tx_frame_sync) |-> tx_frame_sync [*4])
    else $error("frame sync too short");
  a_sync_drop_fall: assert property ($fell(tx_frame_sync) && rx_bit_clock |-> !$fell(mclk))
    else $error("frame sync dropped on the falling edge that takes it");
  a_rx_on_rise: assert property ($changed(rx_frame_sync) || $changed(din) |-> mclk)
    else $error("receive inputs moved near a falling edge");
  a_bit_clock_sync: assert property ((tx_bit_clock || tx_bit_clock == mclk)
    && (rx_bit_clock || rx_bit_clock == mclk))
    else $error("bit clock not tied to master clock");

  c_drive: cover property ($fell(dout_oe_n));
  c_long_word: cover property ($rose(dout_oe_n) && bits_q == 5'h10);
  c_var_clock: cover property ($fell(rx_bit_clock));
endmodule // vcs_assertions

// File: tb/voice_codec_serial_port_tb.sv
// self-checking bench: host and codec port face each other across one link
`timescale 1ns/100ps
module voice_codec_serial_port_tb;
  import vcs_pkg::*;
  localparam int unsigned HALF = 8;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic lin = 1'b0;
  logic var_mode = 1'b0;
  logic start = 1'b0;
  logic [15:0] dev_word = 16'h0000;
  logic [15:0] host_word = 16'h0000;
  logic [15:0] dev_rx, host_rx, wire_sh;
  logic tx_load, dev_rx_valid, dev_var, busy, host_rx_valid;
  int num_errors = 0;
  int samples_checked = 0;
  int wire_cnt = 0;
  int load_cnt = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  vcs_if vcs_if_inst ();
  vcs_device #(.MODE_HOLD(2 * HALF)) vcs_device_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .link(vcs_if_inst), .linear_mode_i(lin), .tx_word_i(dev_word), .tx_load_o(tx_load),
    .rx_word_o(dev_rx), .rx_valid_o(dev_rx_valid), .var_mode_o(dev_var));
  vcs_host #(.MCLK_HALF(HALF)) vcs_host_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .link(vcs_if_inst), .linear_mode_i(lin), .var_mode_i(var_mode), .start_i(start),
    .word_i(host_word), .busy_o(busy), .rx_word_o(host_rx), .rx_valid_o(host_rx_valid));
  vcs_assertions vcs_assertions_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mclk(vcs_if_inst.mclk),
    .tx_frame_sync(vcs_if_inst.tx_frame_sync), .rx_frame_sync(vcs_if_inst.rx_frame_sync),
    .tx_bit_clock(vcs_if_inst.tx_bit_clock), .rx_bit_clock(vcs_if_inst.rx_bit_clock),
    .din(vcs_if_inst.din), .dout(vcs_if_inst.dout), .dout_oe_n(vcs_if_inst.dout_oe_n),
    .tx_slot_strobe_n_oe_n(vcs_if_inst.tx_slot_strobe_n_oe_n));

  // wire-side sampler: bits taken on falling master edges while the strobe is low
  always @(negedge vcs_if_inst.mclk)
  begin
    if (vcs_if_inst.tx_slot_strobe_n === 1'b0)
    begin
      wire_sh = {wire_sh[14:0], vcs_if_inst.dout_line};
      wire_cnt++;
    end
  end

  function automatic logic [15:0] expect_word(input logic [15:0] w, input logic l);
    return l ? w : {8'h00, w[7:0]};
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic set_mode(input logic v, input logic l);
    int i;
    @(posedge clk_sys_i);
    var_mode <= v;
    lin <= l;
    for (i = 0; i < 400 && dev_var !== v; i++)
      @(posedge clk_sys_i);
    #1;
    check("var_mode", {15'h0000, dev_var}, {15'h0000, v});
  endtask

  task automatic run_frame(input logic [15:0] dw, input logic [15:0] hw);
    int i;
    bit hs;
    bit ds;
    logic [15:0] hrx;
    logic [15:0] drx;
    hs = 0;
    ds = 0;
    wire_cnt = 0;
    load_cnt = 0;
    @(posedge clk_sys_i);
    dev_word <= dw;
    host_word <= hw;
    start <= 1'b1;
    @(posedge clk_sys_i);
    start <= 1'b0;
    for (i = 0; i < 2000 && !(hs && ds && busy === 1'b0); i++)
    begin
      @(posedge clk_sys_i);
      #1;
      // a late change of the source word must not reach the wire
      if (tx_load === 1'b1)
      begin
        load_cnt++;
        dev_word <= ~dw;
      end
      if (host_rx_valid === 1'b1)
      begin
        hs = 1;
        hrx = host_rx;
      end
      if (dev_rx_valid === 1'b1)
      begin
        ds = 1;
        drx = dev_rx;
      end
    end
    check("host_done", {15'h0000, hs}, 16'h0001);
    check("dev_done", {15'h0000, ds}, 16'h0001);
    check("host_rx", hrx, expect_word(dw, lin));
    check("dev_rx", drx, expect_word(hw, lin));
    check("wire_bits", wire_cnt[15:0], lin ? 16'h0010 : 16'h0008);
    check("wire_word", expect_word(wire_sh, lin), expect_word(dw, lin));
    check("loads", load_cnt[15:0], 16'h0001);
  endtask

  initial
  begin
    int m;
    int k;
    void'($urandom(32'h5f05));
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (m = 0; m < 4; m++)
    begin
      set_mode(m[1], m[0]);
      run_frame(16'h8001, 16'h7ffe);
      for (k = 0; k < 2; k++)
        run_frame(16'($urandom), 16'($urandom));
    end
    print_verdict();
  end

  // whole run is about 12 frames of at most some 300 cycles plus mode changes
  initial
  begin
    repeat (60000) @(posedge clk_sys_i);
    num_errors++;
    print_verdict();
  end
endmodule // voice_codec_serial_port_tb
